//--- hw/tccu_pkg.sv
/*
  Constants of the timer capture/compare unit: register indices, field
  positions, mode codes and reset values.
  Assumes a 32-bit classic Wishbone bus with word-aligned registers.
*/
package tccu_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Bus layout
  localparam int unsigned ADR_W   = 8;
  localparam int unsigned DAT_W   = 32;
  localparam int unsigned SEL_W   = 4;
  localparam int unsigned IDX_W   = 6;
  localparam int unsigned BYTE_W  = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PAIR_LOW  = 6'h15;
  localparam logic [IDX_W-1:0] IDX_PAIR_HIGH = 6'h16;
  localparam logic [IDX_W-1:0] IDX_CONTROL   = 6'h17;
  localparam logic [IDX_W-1:0] IDX_FLAG      = 6'h18;

  ////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int unsigned MODE_W   = 4;
  localparam int unsigned MODE_LSB = 0;
  localparam int unsigned DUTY_W   = 2;
  localparam int unsigned DUTY_LSB = 4;
  localparam int unsigned CTRL_W   = 6;
  localparam int unsigned FLAG_BIT = 0;

  // Mode codes
  localparam logic [MODE_W-1:0] MODE_OFF       = 4'h0;
  localparam logic [MODE_W-1:0] MODE_CAP_FALL  = 4'h4;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE  = 4'h5;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE16= 4'h7;
  localparam logic [MODE_W-1:0] MODE_CMP_SET   = 4'h8;
  localparam logic [MODE_W-1:0] MODE_CMP_CLR   = 4'h9;
  localparam logic [MODE_W-1:0] MODE_CMP_SOFT  = 4'ha;
  localparam logic [MODE_W-1:0] MODE_CMP_SPEC  = 4'hb;
  localparam logic [1:0]        GRP_CAPTURE    = 2'h1;
  localparam logic [1:0]        GRP_COMPARE    = 2'h2;
  localparam logic [1:0]        GRP_PWM        = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and reset values
  localparam int unsigned       PRE_W     = 4;
  localparam logic [PRE_W-1:0]  PRE_LAST4 = 4'h3;
  localparam logic [PRE_W-1:0]  PRE_LAST16= 4'hf;
  localparam logic [PRE_W-1:0]  PRE_ZERO  = 4'h0;
  localparam logic [CTRL_W-1:0] CTRL_RST  = 6'h00;
  localparam logic [BYTE_W-1:0] PAIR_RST  = 8'h00;

endpackage

//--- hw/tccu_top.sv
/*
  Timer capture/compare unit: 16-bit register pair and a control register
  behind a classic Wishbone slave, capture of the timer on pin edges with
  an edge prescaler, compare against the timer with pin action, software
  flag and special event trigger.
  Assumes a synchronous 16-bit timer count on the same clock and a pin
  level that already reflects any port latch drive onto the shared pin.
*/
// Notes on behaviour
// - Mode selects capture on falling, rising, fourth or sixteenth rising edge.
// - A capture copies the whole 16-bit timer count into the pair.
// - Each capture sets the flag; only software clears it.
// - A new capture overwrites an unread value with no overrun mark.
// - Prescaler counter held at zero when off, not capturing, or reset.
// - Switching between capture prescalers keeps the counter running.
// - Compare mode matches the pair to the timer and acts on equality.
// - Mode 1000 drives output high, 1001 low, both set the flag.
// - Mode 1010 sets only the flag, pin untouched.
// - Mode 1011 sets flag, resets timer, starts conversion if enabled.
// - Special event timer reset is apart from overflow; starts conversion.
// - Flag and pin action on a match happen in the same cycle.
// - Mode 0000 turns the unit off and clears prescaler and match state.
// - Modes 11xx hold duty low bits in control bits 5-4.
// - Control bits 7-6 read zero; bits 5-4 unused outside PWM.
// - Clearing only mode bit 0 from 1001 inverts the output until reset or a write of mode 0000.
// - Port latch writes seen on the pin may cause a capture.
// - Low pair half and the control register are read and write; the high half ignores writes in modes 11xx.
`timescale 1ns/10ps

module tccu_top
  import tccu_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          cyc_i,
  input  wire logic                          stb_i,
  input  wire logic                          we_i,
  input  wire logic [tccu_pkg::ADR_W-1:0]    adr_i,
  input  wire logic [tccu_pkg::SEL_W-1:0]    sel_i,
  input  wire logic [tccu_pkg::DAT_W-1:0]    dat_i,
  output logic      [tccu_pkg::DAT_W-1:0]    dat_o,
  output logic                               ack_o,
  // Timer and converter
  input  wire logic [15:0]                   timer_count_i,
  input  wire logic                          conv_enable_i,
  output logic                               timer_reset_o,
  output logic                               conv_start_o,
  // Shared event pin
  input  wire logic                          pin_i,
  output logic                               compare_out_o,
  output logic                               compare_active_o,
  // Flag
  output logic                               unit_interrupt_flag_o
);

  import tccu_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [BYTE_W-1:0] pair_lo_r;
  logic [BYTE_W-1:0] pair_lo_nxt;
  logic [BYTE_W-1:0] pair_hi_r;
  logic [BYTE_W-1:0] pair_hi_nxt;
  logic              flag_r;
  logic              flag_nxt;
  logic [PRE_W-1:0]  pre_cnt_r;
  logic [PRE_W-1:0]  pre_cnt_nxt;
  logic              match_prev_r;
  logic              invert_r;
  logic              invert_nxt;
  logic              out_latch_r;
  logic              out_latch_nxt;
  logic              ack_r;
  logic [DAT_W-1:0]  rdata_r;
  logic [DAT_W-1:0]  rdata_nxt;
  logic              pin_s1_r;
  logic              pin_s2_r;
  logic              pin_s3_r;
  logic              treset_r;
  logic              conv_r;
  logic              active_r;
  logic              match_prev_nxt;
  logic              treset_nxt;
  logic              conv_nxt;
  logic              active_nxt;

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic [IDX_W-1:0]  idx      = adr_i[IDX_W+1:2];
  wire logic              req      = cyc_i & stb_i;
  wire logic              wr_take  = req & we_i & ack_r & sel_i[0];
  wire logic              sel_lo   = (idx == IDX_PAIR_LOW);
  wire logic              sel_hi   = (idx == IDX_PAIR_HIGH);
  wire logic              sel_ctl  = (idx == IDX_CONTROL);
  wire logic              sel_flg  = (idx == IDX_FLAG);
  wire logic              wr_lo    = wr_take & sel_lo;
  wire logic              wr_hi    = wr_take & sel_hi;
  wire logic              wr_ctl   = wr_take & sel_ctl;
  wire logic              wr_flg   = wr_take & sel_flg;
  wire logic [BYTE_W-1:0] wbyte    = dat_i[BYTE_W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire logic [MODE_W-1:0] mode     = ctrl_r[MODE_LSB +: MODE_W];
  wire logic [1:0]        grp      = mode[MODE_W-1 -: 2];
  wire logic              is_cap   = (grp == GRP_CAPTURE);
  wire logic              is_cmp   = (grp == GRP_COMPARE);
  wire logic              is_pwm   = (grp == GRP_PWM);
  wire logic [MODE_W-1:0] new_mode = wbyte[MODE_LSB +: MODE_W];
  wire logic              to_off   = wr_ctl & (new_mode == MODE_OFF);
  wire logic              to_zero  = wr_ctl & (wbyte[CTRL_W-1:0] == CTRL_RST);
  // Clearing only bit 0 out of clear-on-match
  wire logic              flip_out = wr_ctl & (mode == MODE_CMP_CLR)
                                     & (new_mode == MODE_CMP_SET);

  //////////////////////////////////////////////////////////////////////////
  // Pin edges from synchronised samples
  wire logic pin_rise = pin_s2_r & ~pin_s3_r;
  wire logic pin_fall = ~pin_s2_r & pin_s3_r;

  //////////////////////////////////////////////////////////////////////////
  // Capture event and prescaler
  wire logic pre_last = (mode == MODE_CAP_RISE4)  ? (pre_cnt_r == PRE_LAST4)
                      : (pre_cnt_r == PRE_LAST16);
  wire logic pre_mode = (mode == MODE_CAP_RISE4)
                      | (mode == MODE_CAP_RISE16);
  wire logic cap_evt  = ((mode == MODE_CAP_FALL) & pin_fall)
                      | ((mode == MODE_CAP_RISE) & pin_rise)
                      | (pre_mode & pin_rise & pre_last);

  // Counter runs only in prescaled capture; a switch between the two
  // prescaled modes keeps the count
  assign pre_cnt_nxt = (!is_cap || to_off)      ? PRE_ZERO
                     : (pre_mode && pin_rise)
                       ? (pre_last ? PRE_ZERO
                                   : pre_cnt_r + 4'h1)
                     : pre_cnt_r;

  //////////////////////////////////////////////////////////////////////////
  // Compare match
  wire logic equal    = ({pair_hi_r, pair_lo_r} == timer_count_i);
  wire logic match    = is_cmp & equal & ~match_prev_r;
  wire logic act_set  = match & (mode == MODE_CMP_SET);
  wire logic act_clr  = match & (mode == MODE_CMP_CLR);
  wire logic act_spec = match & (mode == MODE_CMP_SPEC);

  assign invert_nxt = to_off ? 1'b0
                    : (invert_r | flip_out);

  // Pin action; mode 1010 and 1011 leave the latch alone
  assign out_latch_nxt = (to_off || to_zero) ? 1'b0
                       : flip_out ? ~out_latch_r
                       : act_set  ? ~invert_r
                       : act_clr  ? invert_r
                       : out_latch_r;

  //////////////////////////////////////////////////////////////////////////
  // Flag: hardware set wins over a software clear
  wire logic flag_set = cap_evt | match;
  assign flag_nxt = flag_set ? 1'b1
                  : wr_flg   ? wbyte[FLAG_BIT]
                  : flag_r;

  //////////////////////////////////////////////////////////////////////////
  // Register writes; a capture overrides a same-cycle software write
  wire logic [15:0] cap_val = timer_count_i;
  assign pair_lo_nxt = cap_evt ? cap_val[BYTE_W-1:0]
                     : wr_lo   ? wbyte
                     : pair_lo_r;
  assign pair_hi_nxt = cap_evt ? cap_val[15:BYTE_W]
                     : (wr_hi && !is_pwm) ? wbyte
                     : pair_hi_r;
  // Bits 5-4 always stored; in every mode only the bus read data returns them
  assign ctrl_nxt    = wr_ctl ? wbyte[CTRL_W-1:0]
                     : ctrl_r;

  //////////////////////////////////////////////////////////////////////////
  // Read data
  wire logic [DAT_W-1:0] rd_lo  = {{(DAT_W-BYTE_W){1'b0}}, pair_lo_r};
  wire logic [DAT_W-1:0] rd_hi  = {{(DAT_W-BYTE_W){1'b0}}, pair_hi_r};
  wire logic [DAT_W-1:0] rd_ctl = {{(DAT_W-CTRL_W){1'b0}}, ctrl_r};
  wire logic [DAT_W-1:0] rd_flg = {{(DAT_W-1){1'b0}}, flag_r};
  assign rdata_nxt = sel_lo  ? rd_lo
                   : sel_hi  ? rd_hi
                   : sel_ctl ? rd_ctl
                   : sel_flg ? rd_flg
                   : '0;

  //////////////////////////////////////////////////////////////////////////
  // Bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Synchroniser and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_lo_r <= PAIR_RST;
    end else begin
      pair_lo_r <= pair_lo_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pair_hi_r <= PAIR_RST;
    end else begin
      pair_hi_r <= pair_hi_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_r <= PRE_ZERO;
    end else begin
      pre_cnt_r <= pre_cnt_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Match history and output latch
  assign match_prev_nxt = is_cmp & equal & ~to_off;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_prev_r <= 1'b0;
    end else begin
      match_prev_r <= match_prev_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      invert_r <= 1'b0;
    end else begin
      invert_r <= invert_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_latch_r <= 1'b0;
    end else begin
      out_latch_r <= out_latch_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Special event pulses; the timer reset is its own line, not overflow
  assign treset_nxt = act_spec;
  assign conv_nxt   = act_spec & conv_enable_i;
  assign active_nxt = (mode == MODE_CMP_SET) | (mode == MODE_CMP_CLR);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      treset_r <= 1'b0;
    end else begin
      treset_r <= treset_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_r <= 1'b0;
    end else begin
      conv_r <= conv_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign dat_o                 = rdata_r;
  assign ack_o                 = ack_r;
  assign timer_reset_o         = treset_r;
  assign conv_start_o          = conv_r;
  assign compare_out_o         = out_latch_r;
  assign compare_active_o      = active_r;
  assign unit_interrupt_flag_o = flag_r;

endmodule

//--- testbench/tccu_far_end.sv
/*
  Far side model: a 16-bit synchronous timer that feeds the unit.
  Assumes the bench loads, runs and stops it on clk_i.
*/
`timescale 1ns/10ps
module tccu_far_end (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control from bench and unit
  input  wire logic        run_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  input  wire logic        timer_reset_i,
  // Timer count
  output logic      [15:0] count_o
);
  // Special event clears the count and raises no overflow
  always_ff @(posedge clk_i) begin
    if (rst_i || timer_reset_i) count_o <= 16'h0000;
    else if (load_i) count_o <= load_val_i;
    else if (run_i) count_o <= count_o + 16'h0001;
  end
endmodule

//--- testbench/tccu_top_properties.sv
/*
  Port checker of the capture/compare unit.
  Assumes it is bound into tccu_top on its one clock.
*/
`timescale 1ns/10ps
module tccu_checker
  import tccu_pkg::*;
(
  // Clock, reset and bus
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       cyc_i,
  input wire logic                       stb_i,
  input wire logic                       we_i,
  input wire logic [tccu_pkg::ADR_W-1:0] adr_i,
  input wire logic [tccu_pkg::DAT_W-1:0] dat_o,
  input wire logic                       ack_o,
  // Unit outputs
  input wire logic                       timer_reset_o,
  input wire logic                       conv_start_o,
  input wire logic                       compare_out_o,
  input wire logic                       unit_interrupt_flag_o
);
  wire logic wr_any;
  wire logic wr_flag;
  wire logic rd_ctrl;
  assign wr_any  = ack_o && we_i;
  assign wr_flag = wr_any && adr_i[7:2] == IDX_FLAG;
  assign rd_ctrl = ack_o && !we_i && adr_i[7:2] == IDX_CONTROL;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  a_ack_req: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_ack_pulse: assert property (
    ack_o |=> !ack_o) else $error("ack too long");
  a_ack_idle: assert property (
    !(cyc_i && stb_i) |=> !ack_o) else $error("ack unasked");
  a_ctrl_top: assert property (
    rd_ctrl |-> dat_o[31:6] == 26'h0) else $error("control top set");
  a_reset_clear: assert property (
    $fell(rst_i) |-> !(ack_o || unit_interrupt_flag_o || compare_out_o))
    else $error("outputs set after reset");
  a_flag_sticky: assert property (
    $fell(unit_interrupt_flag_o) |-> $past(wr_flag))
    else $error("flag cleared by itself");
  a_out_flag: assert property (
    $changed(compare_out_o) |-> unit_interrupt_flag_o || $past(wr_any))
    else $error("output moved without flag");
  a_trig_pulse: assert property (
    timer_reset_o |=> !timer_reset_o) else $error("trigger too long");
  a_conv_gate: assert property (
    conv_start_o |-> timer_reset_o) else $error("start without trigger");
  a_trig_flag: assert property (
    timer_reset_o |-> unit_interrupt_flag_o || $past(wr_any))
    else $error("trigger without flag");
endmodule
bind tccu_top tccu_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .timer_reset_o(timer_reset_o),
  .conv_start_o(conv_start_o), .compare_out_o(compare_out_o),
  .unit_interrupt_flag_o(unit_interrupt_flag_o));

//--- testbench/tb_timer_capture_compare_unit.sv
/*
  Bench of the capture/compare unit over classic Wishbone.
  Assumes the far side timer model and the bound port checker.
*/
`timescale 1ns/10ps
module tb_timer_capture_compare_unit;
  import tccu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pin = 1'b0;
  logic run = 1'b0, ld_en = 1'b0, cen = 1'b1;
  logic [ADR_W-1:0] adr = 8'h00;
  logic [DAT_W-1:0] dat_w = 32'h0, dat_r;
  logic [15:0] ld_val = 16'h0000, tcount, v;
  logic ack, trst, cstart, cout, cact, flag;
  logic [7:0] q;
  int mismatches = 0, tests_run = 0, cycles = 0;
  logic [3:0] md [4] = '{MODE_CAP_FALL, MODE_CAP_RISE,
                         MODE_CAP_RISE4, MODE_CAP_RISE16};
  int np [4] = '{1, 1, 4, 16};
  logic [3:0] cm [3] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLR};
  logic co [3] = '{1'b1, 1'b1, 1'b0};
  tccu_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat_w), .dat_o(dat_r),
    .ack_o(ack), .timer_count_i(tcount), .conv_enable_i(cen),
    .timer_reset_o(trst), .conv_start_o(cstart), .pin_i(pin),
    .compare_out_o(cout), .compare_active_o(cact),
    .unit_interrupt_flag_o(flag));
  tccu_far_end u_far (.clk_i(clk_i), .rst_i(rst_i), .run_i(run),
    .load_i(ld_en), .load_val_i(ld_val), .timer_reset_i(trst),
    .count_o(tcount));
  always #20 clk_i = ~clk_i;
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge clk_i);
    {cyc, stb, we} <= {2'b11, w};
    adr <= {i, 2'h0};
    dat_w <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = dat_r[7:0];
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk(q, e);
  endtask
  task automatic pls(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      pin <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
  endtask
  task automatic ld(input logic [15:0] x);
    @(posedge clk_i);
    ld_val <= x;
    ld_en <= 1'b1;
    @(posedge clk_i);
    ld_en <= 1'b0;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(IDX_CONTROL, 8'h00);
    wb(1'b1, IDX_PAIR_LOW, 8'h5a);
    wb(1'b1, IDX_PAIR_HIGH, 8'hc3);
    rd(IDX_PAIR_LOW, 8'h5a);
    rd(IDX_PAIR_HIGH, 8'hc3);
    wb(1'b1, IDX_CONTROL, 8'hff);
    rd(IDX_CONTROL, 8'h3f);
    wb(1'b1, IDX_PAIR_HIGH, 8'h11);
    rd(IDX_PAIR_HIGH, 8'hc3);
    wb(1'b1, 6'h30, 8'hff);
    rd(6'h30, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, IDX_CONTROL, 8'h00);
      wb(1'b1, IDX_CONTROL, {4'h0, md[i]});
      wb(1'b1, IDX_FLAG, 8'h00);
      v = 16'ha5c0 + 16'(i);
      pls(np[i] - 1);
      rd(IDX_FLAG, 8'h00);
      ld(v);
      pls(1);
      rd(IDX_FLAG, 8'h01);
      rd(IDX_PAIR_LOW, v[7:0]);
      rd(IDX_PAIR_HIGH, v[15:8]);
      ld(~v);
      pls(np[i]);
      rd(IDX_PAIR_LOW, ~v[7:0]);
    end
    wb(1'b1, IDX_CONTROL, {4'h0, MODE_CAP_RISE4});
    pls(2);
    wb(1'b1, IDX_CONTROL, {4'h0, MODE_CAP_RISE16});
    wb(1'b1, IDX_FLAG, 8'h00);
    pls(13);
    rd(IDX_FLAG, 8'h00);
    pls(1);
    rd(IDX_FLAG, 8'h01);
    wb(1'b1, IDX_CONTROL, 8'h00);
    wb(1'b1, IDX_PAIR_LOW, 8'h40);
    wb(1'b1, IDX_PAIR_HIGH, 8'h00);
    run <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, IDX_FLAG, 8'h00);
      ld(16'h0000);
      wb(1'b1, IDX_CONTROL, {4'h0, cm[k]});
      for (int n = 0; n < 300 && flag !== 1'b1; n++) @(posedge clk_i);
      chk(flag, 1'b1);
      chk(cout, co[k]);
      chk(cact, {15'h0, k != 1});
    end
    wb(1'b1, IDX_CONTROL, {4'h0, MODE_CMP_SET});
    repeat (2) @(posedge clk_i);
    chk(cout, 1'b1);
    wb(1'b1, IDX_FLAG, 8'h00);
    ld(16'h0000);
    wb(1'b1, IDX_CONTROL, {4'h0, MODE_CMP_CLR});
    for (int n = 0; n < 300 && flag !== 1'b1; n++) @(posedge clk_i);
    chk(flag, 1'b1);
    chk(cout, 1'b1);
    wb(1'b1, IDX_FLAG, 8'h00);
    ld(16'h0000);
    wb(1'b1, IDX_CONTROL, {4'h0, MODE_CMP_SPEC});
    for (int n = 0; n < 300 && trst !== 1'b1; n++) @(posedge clk_i);
    chk(cstart, 1'b1);
    chk(cout, 1'b1);
    repeat (2) @(posedge clk_i);
    chk(flag, 1'b1);
    chk(tcount < 16'h0004, 1'b1);
    cen <= 1'b0;
    for (int n = 0; n < 300 && trst !== 1'b1; n++) @(posedge clk_i);
    chk(trst, 1'b1);
    chk(cstart, 1'b0);
    wb(1'b1, IDX_CONTROL, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(cout, 1'b0);
    report_and_stop();
  end
endmodule
